// >>> hdl/crp_axi_slave.sv
`timescale 1ns/10ps
`include "crp_params.svh"
module crp_axi_slave (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Write address and data
    input logic awvalid,
    output logic awready,
    input logic [31:0] awaddr,
    input logic wvalid,
    output logic wready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    // Write response
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // Read address
    input logic arvalid,
    output logic arready,
    input logic [31:0] araddr,
    // Read data
    output logic rvalid,
    input logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Register file side
    output logic wr_en,
    output logic [31:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input logic wr_err,
    output logic rd_en,
    output logic [31:0] rd_addr,
    input logic [31:0] rd_data,
    input logic rd_err
);

    logic aw_full_ff, w_full_ff, ar_full_ff;
    logic awready_ff, wready_ff, arready_ff, bvalid_ff, rvalid_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] awaddr_ff, wdata_ff, araddr_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_take, w_take, ar_take;
    logic nxt_aw_full, nxt_w_full, nxt_ar_full, nxt_bvalid, nxt_rvalid;

    assign aw_take = awvalid && awready_ff;
    assign w_take = wvalid && wready_ff;
    assign ar_take = arvalid && arready_ff;
    // The write is done once both halves are held and no answer waits.
    assign wr_en = aw_full_ff && w_full_ff && !bvalid_ff;
    assign rd_en = ar_full_ff && !rvalid_ff;
    assign nxt_aw_full = aw_take || (aw_full_ff && !wr_en);
    assign nxt_w_full = w_take || (w_full_ff && !wr_en);
    assign nxt_ar_full = ar_take || (ar_full_ff && !rd_en);
    assign nxt_bvalid = wr_en || (bvalid_ff && !bready);
    assign nxt_rvalid = rd_en || (rvalid_ff && !rready);
    assign wr_addr = awaddr_ff;
    assign wr_data = wdata_ff;
    assign wr_strb = wstrb_ff;
    assign rd_addr = araddr_ff;
    assign awready = awready_ff;
    assign wready = wready_ff;
    assign arready = arready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            ar_full_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            arready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            rvalid_ff <= 1'b0;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            ar_full_ff <= nxt_ar_full;
            awready_ff <= !nxt_aw_full;
            wready_ff <= !nxt_w_full;
            arready_ff <= !nxt_ar_full;
            bvalid_ff <= nxt_bvalid;
            rvalid_ff <= nxt_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff <= 32'h0000_0000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            araddr_ff <= 32'h0000_0000;
            bresp_ff <= `CRP_RESP_OKAY;
            rresp_ff <= `CRP_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else begin
            if (aw_take) begin
                awaddr_ff <= awaddr;
            end
            if (w_take) begin
                wdata_ff <= wdata;
                wstrb_ff <= wstrb;
            end
            if (ar_take) begin
                araddr_ff <= araddr;
            end
            if (wr_en) begin
                bresp_ff <= wr_err ? `CRP_RESP_SLVERR : `CRP_RESP_OKAY;
            end
            if (rd_en) begin
                rdata_ff <= rd_data;
                rresp_ff <= rd_err ? `CRP_RESP_SLVERR : `CRP_RESP_OKAY;
            end
        end
    end

endmodule: crp_axi_slave

// >>> hdl/crp_gap_counter.sv
`timescale 1ns/10ps
module crp_gap_counter (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Control
    input logic load,
    input logic [7:0] load_count,
    input logic tick,
    // Status
    output logic busy
);

    logic [7:0] cnt_ff;
    logic busy_ff;
    logic last_tick;

    assign last_tick = busy_ff && tick && (cnt_ff == 8'h01);
    assign busy = busy_ff;

    // A zero count is refused at the register, so busy always lasts
    // at least one sync tick.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
        end else if (load) begin
            cnt_ff <= load_count;
            busy_ff <= 1'b1;
        end else if (busy_ff && tick) begin
            cnt_ff <= cnt_ff - 8'h01;
            busy_ff <= !last_tick;
        end
    end

endmodule: crp_gap_counter

// >>> hdl/crp_pacer.sv
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "crp_params.svh"
// Summary of operation
// - Request carries configured level zero to seven.
// - Burst limit: powers of two, 2..256.
// - Release bus at limit, then wait.
// - Count 1..255 sync ticks before re-request.
// - Disk and tape keep separate limit, gap.
// - Selectable disk or tape interrupt priority.
module crp_pacer (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite write
    input logic awvalid,
    output logic awready,
    input logic [31:0] awaddr,
    input logic wvalid,
    output logic wready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input logic arvalid,
    output logic arready,
    input logic [31:0] araddr,
    output logic rvalid,
    input logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Data path requests
    input logic disk_xfer_req,
    input logic tape_xfer_req,
    // Burst channel bus
    input logic channel_sync_tick,
    input logic bus_grant,
    input logic word_done,
    output logic bus_req,
    output logic [2:0] channel_request_level,
    output logic disk_xfer_go,
    output logic tape_xfer_go,
    output logic disk_irq_high
);

    logic [2:0] lvl_ff;
    logic disk_high_ff;
    logic [8:0] disk_lim_ff, tape_lim_ff, lim_ff, word_cnt_ff;
    logic [7:0] disk_gap_ff, tape_gap_ff;
    crp_pkg::crp_state_t state_ff, nxt_state;
    logic act_tape_ff, nxt_act_tape;
    logic [8:0] nxt_lim, nxt_word_cnt;
    logic bus_req_ff, disk_go_ff, tape_go_ff, irq_hi_ff;
    logic [2:0] level_out_ff;
    logic gap_load, gap_busy;
    logic [7:0] gap_value;

    logic wr_en, wr_err, rd_en, rd_err;
    logic [31:0] wr_addr, wr_data, rd_addr, rd_data;
    logic [3:0] wr_strb;

    // Byte lanes not strobed keep the register's present contents.
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction: merge_strb

    function automatic logic [31:0] pack_cfg(input logic [8:0] lim,
                                             input logic [7:0] gap);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[`CRP_LIM_MSB:`CRP_LIM_LSB] = lim;
        r[`CRP_GAP_MSB:`CRP_GAP_LSB] = gap;
        return r;
    endfunction: pack_cfg

    function automatic logic burst_legal(input logic [8:0] lim);
        return (lim >= 9'h002) && ((lim & (lim - 9'h001)) == 9'h000);
    endfunction: burst_legal

    crp_axi_slave u_axi (
        .aclk(aclk),
        .aresetn(aresetn),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Register decode.
    logic [31:0] ctrl_word, disk_word, tape_word, stat_word;
    logic [31:0] ctrl_cand, disk_cand, tape_cand;
    logic hit_ctrl, hit_disk, hit_tape, hit_stat;
    logic disk_ok, tape_ok;

    assign ctrl_word = {27'h000_0000, disk_high_ff, 1'b0, lvl_ff};
    assign disk_word = pack_cfg(disk_lim_ff, disk_gap_ff);
    assign tape_word = pack_cfg(tape_lim_ff, tape_gap_ff);
    assign stat_word = {15'h0000, word_cnt_ff, 3'h0, gap_busy,
                        bus_req_ff, act_tape_ff, state_ff};
    assign ctrl_cand = merge_strb(ctrl_word, wr_data, wr_strb);
    assign disk_cand = merge_strb(disk_word, wr_data, wr_strb);
    assign tape_cand = merge_strb(tape_word, wr_data, wr_strb);
    assign hit_ctrl = wr_addr == `CRP_OFF_CTRL;
    assign hit_disk = wr_addr == `CRP_OFF_DISK;
    assign hit_tape = wr_addr == `CRP_OFF_TAPE;
    // Illegal burst limits and a zero gap are refused whole with SLVERR.
    assign disk_ok = burst_legal(disk_cand[`CRP_LIM_MSB:`CRP_LIM_LSB])
        && (disk_cand[`CRP_GAP_MSB:`CRP_GAP_LSB] != 8'h00);
    assign tape_ok = burst_legal(tape_cand[`CRP_LIM_MSB:`CRP_LIM_LSB])
        && (tape_cand[`CRP_GAP_MSB:`CRP_GAP_LSB] != 8'h00);
    assign wr_err = !(hit_ctrl || (hit_disk && disk_ok)
        || (hit_tape && tape_ok));
    assign hit_stat = rd_addr == `CRP_OFF_STAT;
    assign rd_data = (rd_addr == `CRP_OFF_CTRL) ? ctrl_word :
                     (rd_addr == `CRP_OFF_DISK) ? disk_word :
                     (rd_addr == `CRP_OFF_TAPE) ? tape_word :
                     hit_stat ? stat_word : 32'h0000_0000;
    assign rd_err = !(hit_stat || rd_addr == `CRP_OFF_CTRL
        || rd_addr == `CRP_OFF_DISK || rd_addr == `CRP_OFF_TAPE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_ff <= `CRP_RST_LVL;
            disk_high_ff <= `CRP_RST_DHI;
            disk_lim_ff <= `CRP_RST_LIM;
            disk_gap_ff <= `CRP_RST_GAP;
            tape_lim_ff <= `CRP_RST_LIM;
            tape_gap_ff <= `CRP_RST_GAP;
        end else if (wr_en && !wr_err) begin
            if (hit_ctrl) begin
                lvl_ff <= ctrl_cand[`CRP_LVL_MSB:`CRP_LVL_LSB];
                disk_high_ff <= ctrl_cand[`CRP_DHI_BIT];
            end
            if (hit_disk) begin
                disk_lim_ff <= disk_cand[`CRP_LIM_MSB:`CRP_LIM_LSB];
                disk_gap_ff <= disk_cand[`CRP_GAP_MSB:`CRP_GAP_LSB];
            end
            if (hit_tape) begin
                tape_lim_ff <= tape_cand[`CRP_LIM_MSB:`CRP_LIM_LSB];
                tape_gap_ff <= tape_cand[`CRP_GAP_MSB:`CRP_GAP_LSB];
            end
        end
    end

    // Pacing state machine.
    logic any_req, pick_tape, chan_req, word_hit;

    assign any_req = disk_xfer_req || tape_xfer_req;
    // With both pending, the higher interrupt priority function goes first.
    assign pick_tape = tape_xfer_req
        && (!disk_xfer_req || !disk_high_ff);
    assign chan_req = act_tape_ff ? tape_xfer_req : disk_xfer_req;
    assign word_hit = word_done && (word_cnt_ff + 9'h001 == lim_ff);
    assign gap_value = act_tape_ff ? tape_gap_ff : disk_gap_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_act_tape = act_tape_ff;
        nxt_lim = lim_ff;
        nxt_word_cnt = word_cnt_ff;
        gap_load = 1'b0;
        unique case (state_ff)
            crp_pkg::st_idle: begin
                if (any_req) begin
                    nxt_state = crp_pkg::st_req;
                    nxt_act_tape = pick_tape;
                    // The limit is latched so a write mid-burst cannot
                    // move the end of the current burst.
                    nxt_lim = pick_tape ? tape_lim_ff : disk_lim_ff;
                    nxt_word_cnt = 9'h000;
                end
            end
            crp_pkg::st_req: begin
                if (!chan_req) begin
                    nxt_state = crp_pkg::st_idle;
                end else if (bus_grant) begin
                    nxt_state = crp_pkg::st_xfer;
                end
            end
            crp_pkg::st_xfer: begin
                if (word_hit || !chan_req) begin
                    nxt_state = crp_pkg::st_gap;
                    gap_load = 1'b1;
                end else if (word_done) begin
                    nxt_word_cnt = word_cnt_ff + 9'h001;
                end
            end
            crp_pkg::st_gap: begin
                if (!gap_busy) begin
                    nxt_state = crp_pkg::st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= crp_pkg::st_idle;
            act_tape_ff <= 1'b0;
            lim_ff <= `CRP_RST_LIM;
            word_cnt_ff <= 9'h000;
        end else begin
            state_ff <= nxt_state;
            act_tape_ff <= nxt_act_tape;
            lim_ff <= nxt_lim;
            word_cnt_ff <= nxt_word_cnt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_req_ff <= 1'b0;
            disk_go_ff <= 1'b0;
            tape_go_ff <= 1'b0;
            level_out_ff <= `CRP_RST_LVL;
            irq_hi_ff <= `CRP_RST_DHI;
        end else begin
            bus_req_ff <= (nxt_state == crp_pkg::st_req)
                || (nxt_state == crp_pkg::st_xfer);
            disk_go_ff <= (nxt_state == crp_pkg::st_xfer) && !nxt_act_tape;
            tape_go_ff <= (nxt_state == crp_pkg::st_xfer) && nxt_act_tape;
            level_out_ff <= lvl_ff;
            irq_hi_ff <= disk_high_ff;
        end
    end

    assign bus_req = bus_req_ff;
    assign channel_request_level = level_out_ff;
    assign disk_xfer_go = disk_go_ff;
    assign tape_xfer_go = tape_go_ff;
    assign disk_irq_high = irq_hi_ff;

    crp_gap_counter u_gap (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(gap_load),
        .load_count(gap_value),
        .tick(channel_sync_tick),
        .busy(gap_busy)
    );

    // Helper logic for the checks below: ticks seen during the gap.
    logic [7:0] gap_val_ff, ticks_ff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_val_ff <= 8'h00;
            ticks_ff <= 8'h00;
        end else if (gap_load) begin
            gap_val_ff <= gap_value;
            ticks_ff <= 8'h00;
        end else if (state_ff == crp_pkg::st_gap && channel_sync_tick) begin
            ticks_ff <= ticks_ff + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    level_follows_a: assert property (
        $rose(bus_req_ff) |-> channel_request_level == $past(lvl_ff))
        else $error("request level differs from configured level");
    limit_legal_a: assert property (
        burst_legal(disk_lim_ff) && burst_legal(tape_lim_ff)
        && burst_legal(lim_ff))
        else $error("burst limit is not a legal power of two");
    burst_bound_a: assert property (
        state_ff == crp_pkg::st_xfer |-> word_cnt_ff < lim_ff)
        else $error("word count reached the burst limit in transfer");
    release_at_limit_a: assert property (
        (state_ff == crp_pkg::st_xfer && word_hit)
        |=> !bus_req_ff && !disk_xfer_go && !tape_xfer_go
            && state_ff == crp_pkg::st_gap)
        else $error("bus not released at burst limit");
    gap_length_a: assert property (
        (state_ff == crp_pkg::st_gap && !gap_busy)
        |-> ticks_ff == gap_val_ff && gap_val_ff != 8'h00)
        else $error("gap ended after wrong number of sync ticks");
    gap_blocks_a: assert property (
        gap_load |=> gap_busy && !bus_req_ff && (gap_val_ff ==
            ($past(act_tape_ff) ? $past(tape_gap_ff) : $past(disk_gap_ff))))
        else $error("gap not loaded from active channel or request seen");
    chan_limit_a: assert property (
        $rose(bus_req_ff) |-> lim_ff == (act_tape_ff
            ? $past(tape_lim_ff) : $past(disk_lim_ff)))
        else $error("burst limit not taken from the active channel");
    irq_pick_a: assert property (
        (state_ff == crp_pkg::st_idle && disk_xfer_req && tape_xfer_req)
        |=> act_tape_ff == !$past(disk_high_ff))
        else $error("channel choice ignores interrupt priority");

    burst_end_c: cover property (
        state_ff == crp_pkg::st_xfer && word_hit);
    gap_exit_c: cover property (
        state_ff == crp_pkg::st_gap ##1 state_ff == crp_pkg::st_idle);
    both_req_c: cover property (
        state_ff == crp_pkg::st_idle && disk_xfer_req && tape_xfer_req);
    tape_burst_c: cover property (tape_xfer_go ##[1:20] !tape_xfer_go);

endmodule: crp_pacer

// >>> hdl/crp_params.svh
`ifndef CRP_PARAMS_SVH
`define CRP_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus.
`define CRP_OFF_CTRL 32'h0000_0000
`define CRP_OFF_DISK 32'h0000_0004
`define CRP_OFF_TAPE 32'h0000_0008
`define CRP_OFF_STAT 32'h0000_000C

// Control register fields.
`define CRP_LVL_MSB 2
`define CRP_LVL_LSB 0
`define CRP_DHI_BIT 4

// Channel configuration register fields.
`define CRP_LIM_MSB 8
`define CRP_LIM_LSB 0
`define CRP_GAP_MSB 23
`define CRP_GAP_LSB 16

// Reset values.
`define CRP_RST_LVL 3'h0
`define CRP_RST_DHI 1'b1
`define CRP_RST_LIM 9'h020
`define CRP_RST_GAP 8'h04

// AXI responses.
`define CRP_RESP_OKAY 2'h0
`define CRP_RESP_SLVERR 2'h2

`endif

// >>> hdl/crp_pkg.sv
package crp_pkg;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_req = 2'b01,
        st_xfer = 2'b10,
        st_gap = 2'b11
    } crp_state_t;

endpackage: crp_pkg

// >>> tb/channel_request_pacer_tb.sv
`timescale 1ns/10ps
`include "crp_params.svh"
module channel_request_pacer_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, slow;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic disk_xfer_req, tape_xfer_req, channel_sync_tick, bus_grant;
    logic word_done, bus_req, disk_xfer_go, tape_xfer_go, disk_irq_high;
    logic [2:0] channel_request_level;
    logic [8:0] words, gap_ticks;
    logic [15:0] seed;
    int n_mismatch = 0;
    int total_checks = 0;
    localparam logic [1:0] rsp_ok = `CRP_RESP_OKAY;
    localparam logic [1:0] rsp_err = `CRP_RESP_SLVERR;
    localparam logic [8:0] bad_lim [0:2] = '{9'h000, 9'h003, 9'h101};

    crp_pacer u_crp_pacer (.aclk, .aresetn, .awvalid, .awready, .awaddr,
        .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .disk_xfer_req, .tape_xfer_req, .channel_sync_tick, .bus_grant,
        .word_done, .bus_req, .channel_request_level, .disk_xfer_go,
        .tape_xfer_go, .disk_irq_high);
    crp_bus_model u_crp_bus_model (.aclk, .aresetn, .bus_req,
        .disk_xfer_go, .tape_xfer_go, .slow, .bus_grant, .word_done,
        .channel_sync_tick, .words, .gap_ticks);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction: lfsr

    function automatic logic [31:0] cfg(input logic [8:0] l,
                                        input logic [7:0] g);
        return {8'h00, g, 7'h00, l};
    endfunction: cfg

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask: print_verdict

    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask: check

    task automatic timeout;
        $display("CHECK FAILED wait expected done seen hang");
        n_mismatch++;
        print_verdict();
    endtask: timeout

    // Samples at each edge the value that stood just before it.
    task automatic wait_for(input int s, input logic v);
        for (int n = 0; n < 4000; n++) begin
            @(posedge aclk);
            if ((s == 0 ? disk_xfer_go : s == 1 ? tape_xfer_go :
                 s == 2 ? bus_req : disk_xfer_go | tape_xfer_go) === v) begin
                return;
            end
        end
        timeout();
    endtask: wait_for

    task automatic wr(input logic [31:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                check("bresp", {30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask: wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                check("rresp", {30'h0, rresp}, {30'h0, er});
                check("rdata", rdata, e);
                rready <= 1'b0;
                return;
            end
        end
        timeout();
    endtask: rd

    task automatic run(input logic tp, input logic [8:0] l,
                       input logic [7:0] g, input logic sl);
        wait_for(2, 1'b0);
        wr(tp ? `CRP_OFF_TAPE : `CRP_OFF_DISK, cfg(l, g), rsp_ok);
        slow <= sl;
        if (tp) tape_xfer_req <= 1'b1;
        else disk_xfer_req <= 1'b1;
        wait_for(tp, 1'b1);
        wait_for(tp, 1'b0);
        check("words", {23'h0, words}, {23'h0, l});
        wait_for(2, 1'b1);
        @(posedge aclk);
        check("gap", {23'h0, gap_ticks}, {24'h0, g});
        disk_xfer_req <= 1'b0;
        tape_xfer_req <= 1'b0;
    endtask: run

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, slow} = 7'h00;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hF;
        {disk_xfer_req, tape_xfer_req} = 2'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`CRP_OFF_CTRL, 32'h0000_0010, rsp_ok);
        rd(`CRP_OFF_DISK, cfg(9'h020, 8'h04), rsp_ok);
        rd(`CRP_OFF_TAPE, cfg(9'h020, 8'h04), rsp_ok);
        rd(32'h0000_0010, 32'h0, rsp_err);
        wr(32'h0000_0010, 32'h0, rsp_err);
        wr(`CRP_OFF_STAT, 32'h0, rsp_err);
        for (int i = 0; i < 8; i++) begin
            wr(`CRP_OFF_CTRL, i, rsp_ok);
            repeat (2) @(posedge aclk);
            check("level", {29'h0, channel_request_level}, i);
            check("irq", {31'h0, disk_irq_high}, 32'h0);
        end
        for (int e = 1; e < 9; e++) begin
            wr(`CRP_OFF_DISK, cfg(9'h001 << e, 8'h04), rsp_ok);
        end
        for (int i = 0; i < 3; i++) begin
            wr(`CRP_OFF_DISK, cfg(bad_lim[i], 8'h04), rsp_err);
        end
        wr(`CRP_OFF_DISK, cfg(9'h020, 8'h00), rsp_err);
        rd(`CRP_OFF_DISK, cfg(9'h100, 8'h04), rsp_ok);
        run(1'b0, 9'h020, 8'h04, 1'b0);
        run(1'b0, 9'h100, 8'h01, 1'b0);
        run(1'b1, 9'h002, 8'hFF, 1'b1);
        rd(`CRP_OFF_DISK, cfg(9'h100, 8'h01), rsp_ok);
        seed = 16'h002A;
        repeat (4) begin
            seed = lfsr(seed);
            run(seed[0], 9'h002 << seed[2:1], {5'h00, seed[5:3]} + 8'h01,
                seed[6]);
        end
        for (int i = 0; i < 2; i++) begin
            wait_for(2, 1'b0);
            wr(`CRP_OFF_CTRL, {27'h0, ~i[0], 4'h5}, rsp_ok);
            disk_xfer_req <= 1'b1;
            tape_xfer_req <= 1'b1;
            wait_for(3, 1'b1);
            check("disk first", {31'h0, disk_xfer_go},
                  {31'h0, ~i[0]});
            check("irq", {31'h0, disk_irq_high}, {31'h0, ~i[0]});
            disk_xfer_req <= 1'b0;
            tape_xfer_req <= 1'b0;
        end
        print_verdict();
    end
endmodule: channel_request_pacer_tb

// >>> tb/crp_bus_model.sv
`timescale 1ns/10ps
module crp_bus_model (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Device side
    input logic bus_req,
    input logic disk_xfer_go,
    input logic tape_xfer_go,
    input logic slow,
    // Arbiter side
    output logic bus_grant,
    output logic word_done,
    output logic channel_sync_tick,
    // Measurements
    output logic [8:0] words,
    output logic [8:0] gap_ticks
);
    logic [2:0] tick_ff;
    logic [3:0] wait_ff;
    logic [8:0] run_ff;
    logic req_d_ff;
    logic go_d_ff;
    logic go;

    assign go = disk_xfer_go | tape_xfer_go;

    // A slow arbiter waits before granting and moves a word every other
    // cycle, so the device cannot lean on a fixed grant latency.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_ff <= 3'h0;
            wait_ff <= 4'h0;
            run_ff <= 9'h000;
            req_d_ff <= 1'b0;
            go_d_ff <= 1'b0;
            bus_grant <= 1'b0;
            word_done <= 1'b0;
            channel_sync_tick <= 1'b0;
            words <= 9'h000;
            gap_ticks <= 9'h000;
        end else begin
            tick_ff <= (tick_ff == 3'h6) ? 3'h0 : tick_ff + 3'h1;
            channel_sync_tick <= (tick_ff == 3'h6);
            wait_ff <= bus_req ? wait_ff + {3'h0, wait_ff != 4'hF} : 4'h0;
            // Only one requester sits on this bus, so its level never
            // clashes with another.
            bus_grant <= bus_req && (wait_ff >= (slow ? 4'h5 : 4'h0));
            word_done <= go && !(slow && word_done);
            req_d_ff <= bus_req;
            go_d_ff <= go;
            if (go && !go_d_ff) begin
                words <= 9'h000;
            end else if (go && word_done) begin
                words <= words + 9'h001;
            end
            run_ff <= (req_d_ff ? 9'h000 : run_ff)
                + {8'h00, !bus_req && channel_sync_tick};
            if (bus_req && !req_d_ff) begin
                gap_ticks <= run_ff;
            end
        end
    end
endmodule: crp_bus_model
